// file: lsw_clock_ctrl.sv
`timescale 1ns/1ps
`include "lsw_defines.svh"

module lsw_clock_ctrl #(
  parameter int NUM_DIG  = 8,
  parameter int NUM_ANA  = 4,
  parameter int SKEW_LEN = 16
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // oscillator pins: 0 main, 1 crystal, 2 routed, 3 pll, 4 doubler, 5 fast lp, 6 watch, 7 heartbeat
  input  wire logic [7:0]                   oscIn,
  input  wire logic                         cpuHalted,
  input  wire logic                         intWake,
  input  wire logic                         pinWake,
  input  wire logic [7:0]                   addr,
  input  wire logic [31:0]                  wrData,
  input  wire logic                         wrStb,
  input  wire logic                         rdStb,
  output logic [31:0]                       rdData,
  output logic                              heartbeatClock,
  output logic                              fastLowpowerClock,
  output logic                              dividedLowpowerClock,
  output logic                              slowWakeIrq,
  output logic                              fastWakeIrq,
  output logic                              rtcIrq,
  output logic                              sysClk,
  output logic                              busClk,
  output logic                              cpuClk,
  output logic [NUM_DIG-1:0]                digClk,
  output logic [NUM_ANA-1:0]                anaClk,
  output logic                              usbClk,
  output logic [1:0]                        powerMode,
  output logic [`LSW_TMPL_W-1:0]            subsysEnable
);

  localparam int NUM_DIV  = 1 + NUM_DIG + NUM_ANA;
  localparam int ANA_BASE = 1 + NUM_DIG;

  function automatic logic [15:0] effDiv(input logic [15:0] d);
    effDiv = (d < `LSW_DIV_MIN) ? `LSW_DIV_MIN : d;
  endfunction : effDiv

  function automatic logic pick8(input logic [7:0] v, input logic [2:0] sel);
    pick8 = v[sel];
  endfunction : pick8

  // pin synchroniser; a level only changes once stages two and three agree
  logic [7:0] syncA;
  logic [7:0] syncB;
  logic [7:0] syncC;
  logic [7:0] oscLvl;
  logic [7:0] oscPrev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA   <= 8'h00;
      syncB   <= 8'h00;
      syncC   <= 8'h00;
      oscLvl  <= 8'h00;
      oscPrev <= 8'h00;
    end else begin
      syncA   <= oscIn;
      syncB   <= syncA;
      syncC   <= syncB;
      oscLvl  <= (~(syncB ^ syncC) & syncC) | ((syncB ^ syncC) & oscLvl);
      oscPrev <= oscLvl;
    end
  end

  wire [7:0] oscRise = oscLvl & ~oscPrev;
  wire [7:0] oscEdge = oscLvl ^ oscPrev;

  // registers
  lsw_pkg::lsw_mode_e    mode;
  logic [`LSW_TMPL_W-1:0] actTmpl;
  logic [`LSW_TMPL_W-1:0] altTmpl;
  logic [31:0]            slowCfg;
  logic [31:0]            fastCfg;
  logic [1:0]             usbSel;
  logic [31:0]            divCfg [NUM_DIV];
  logic [12:0]            slowCnt;
  logic [4:0]             fastCnt;
  logic [14:0]            rtcCnt;
  logic [1:0]             div3Cnt;

  wire isHib   = (mode == lsw_pkg::LSW_HIBERNATE);
  wire isSleep = (mode == lsw_pkg::LSW_SLEEP);
  wire isRun   = !isHib && !isSleep;

  wire wrMode    = wrStb && (addr == `LSW_OFF_MODE);
  wire wrAct     = wrStb && (addr == `LSW_OFF_ACT_TMPL);
  wire wrAlt     = wrStb && (addr == `LSW_OFF_ALT_TMPL);
  wire wrSlow    = wrStb && (addr == `LSW_OFF_SLOW_CFG);
  wire wrFast    = wrStb && (addr == `LSW_OFF_FAST_CFG);
  wire wrUsb     = wrStb && (addr == `LSW_OFF_USB_CFG);
  wire divSpace  = (addr[7:6] == 2'(`LSW_OFF_DIV_BASE >> 6)) && (addr[1:0] == 2'h0);
  wire [3:0] divIdx = addr[5:2];
  wire divHit    = divSpace && (32'(divIdx) < NUM_DIV);

  // slow wake counter
  wire heartbeatTick = oscRise[7];
  wire slowRun       = !isHib && !cpuHalted;
  wire slowSwReset   = wrSlow && wrData[`LSW_SC_RESET];
  wire [12:0] next_slowCnt = slowCnt + 13'h0001;
  wire [3:0]  slowIvl  = slowCfg[`LSW_SC_IVL_HI:`LSW_SC_IVL_LO];
  wire [12:0] slowMask = 13'((14'h0001 << slowIvl) - 14'h0001);
  wire slowEvent = slowRun && heartbeatTick && !slowSwReset
                   && ((next_slowCnt & slowMask) == 13'h0000);

  // fast wake counter
  wire fastTick  = oscRise[5];
  wire [4:0] fastTc = fastCfg[`LSW_FC_TC_HI:`LSW_FC_TC_LO];
  wire fastHit   = !isHib && fastTick && (fastCnt == fastTc);

  // once-per-second tick from the watch crystal
  wire rtcEvent  = !isHib && oscRise[6] && (rtcCnt == `LSW_WATCH_PER_SEC);

  // wake decision: sleep takes timed, rtc and interrupt wakes; hibernate only pins
  wire sleepWake = (slowEvent && slowCfg[`LSW_SC_WAKE])
                   || (fastHit && fastCfg[`LSW_FC_WAKE])
                   || rtcEvent || intWake;
  wire wakeNow   = (isSleep && sleepWake) || (isHib && pinWake)
                   || (mode == lsw_pkg::LSW_ALT_ACTIVE && intWake);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= lsw_pkg::LSW_ACTIVE;
    end else if (wakeNow) begin
      mode <= lsw_pkg::LSW_ACTIVE;
    end else if (wrMode) begin
      mode <= lsw_pkg::lsw_mode_e'(wrData[1:0]);
    end
  end

  // a wake forces the processor bit on, winning over a template write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actTmpl <= `LSW_RST_TMPL;
      altTmpl <= `LSW_RST_TMPL;
    end else begin
      if (wrAct) begin
        actTmpl <= wrData[`LSW_TMPL_W-1:0];
      end
      if (wakeNow) begin
        actTmpl[`LSW_TB_CPU] <= 1'b1;
      end
      if (wrAlt) begin
        altTmpl <= wrData[`LSW_TMPL_W-1:0];
      end
    end
  end

  // settings are only written by software, so sleep and hibernate keep them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slowCfg <= `LSW_RST_SLOW_CFG;
      fastCfg <= `LSW_RST_FAST_CFG;
      usbSel  <= 2'h0;
    end else begin
      if (wrSlow) begin
        slowCfg <= wrData & 32'h0000_00F3;
      end
      if (wrFast) begin
        fastCfg <= wrData & 32'h0000_1F03;
      end
      if (wrUsb) begin
        usbSel <= wrData[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slowCnt <= 13'h0000;
    end else if (slowSwReset) begin
      slowCnt <= 13'h0000;
    end else if (slowRun && heartbeatTick) begin
      slowCnt <= next_slowCnt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastCnt <= 5'h00;
    end else if (fastHit) begin
      fastCnt <= 5'h00;
    end else if (!isHib && fastTick) begin
      fastCnt <= fastCnt + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtcCnt <= 15'h0000;
    end else if (!isHib && oscRise[6]) begin
      rtcCnt <= rtcCnt + 15'h0001;
    end
  end

  // low-speed outputs; divide-by-three counts fast low-power rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div3Cnt              <= 2'h0;
      dividedLowpowerClock <= 1'b0;
      heartbeatClock       <= 1'b0;
      fastLowpowerClock    <= 1'b0;
    end else begin
      if (fastTick) begin
        div3Cnt              <= (div3Cnt == `LSW_LP_DIV3_LAST) ? 2'h0 : div3Cnt + 2'h1;
        dividedLowpowerClock <= (div3Cnt == `LSW_LP_DIV3_LAST);
      end
      heartbeatClock    <= oscLvl[7] && !isHib;
      fastLowpowerClock <= oscLvl[5] && !isHib;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slowWakeIrq <= 1'b0;
      fastWakeIrq <= 1'b0;
      rtcIrq      <= 1'b0;
    end else begin
      slowWakeIrq <= slowEvent && slowCfg[`LSW_SC_IRQ];
      fastWakeIrq <= fastHit && fastCfg[`LSW_FC_IRQ];
      rtcIrq      <= rtcEvent;
    end
  end

  // dividers: 0 is the bus divider, then digital, then analog
  logic [NUM_DIV-1:0] divWrap;
  logic [NUM_DIV-1:0] divOut;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DIV; i++) begin
        divCfg[i] <= (i == 0) ? `LSW_RST_BUS_DIV : `LSW_RST_DIV;
      end
    end else if (wrStb && divHit) begin
      divCfg[divIdx] <= wrData & 32'h01F7_FFFF;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_DIV; g++) begin : gDiv
      logic [15:0] cnt;
      logic        out;
      // slot 7 chains in the previous divider, giving up to 32 bits in two stages
      wire         chainIn = (g == 0) ? 1'b0 : divWrap[(g == 0) ? 0 : g - 1];
      wire [7:0]   pickIn  = {chainIn, oscRise[6:0]};
      wire         tick    = pick8(pickIn, divCfg[g][`LSW_DV_SRC_HI:`LSW_DV_SRC_LO]);
      wire [15:0]  dEff    = effDiv(divCfg[g][`LSW_DV_DIV_HI:0]);
      wire         wrapNow = tick && (cnt >= dEff - 16'h0001);
      wire [15:0]  next_cnt = wrapNow ? 16'h0000 : cnt + 16'h0001;

      // output is a flop on clk, so it is resynchronised and glitch free
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= 16'h0000;
          out <= 1'b0;
        end else if (!isHib && tick) begin
          cnt <= next_cnt;
          out <= (next_cnt < (dEff >> 1));
        end
      end

      assign divWrap[g] = wrapNow && !isHib;
      assign divOut[g]  = out;
    end
  endgenerate

  // analog skew: delay each analog divider output by a programmable tap
  logic [SKEW_LEN-1:0] skewLine [NUM_ANA];
  logic [NUM_ANA-1:0]  anaSkewed;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < NUM_ANA; a++) begin
        skewLine[a] <= '0;
      end
    end else begin
      for (int a = 0; a < NUM_ANA; a++) begin
        skewLine[a] <= {skewLine[a][SKEW_LEN-2:0], divOut[ANA_BASE + a]};
      end
    end
  end

  always_comb begin
    for (int a = 0; a < NUM_ANA; a++) begin
      anaSkewed[a] = skewLine[a][divCfg[ANA_BASE + a][`LSW_DV_SKEW_HI:`LSW_DV_SKEW_LO]];
    end
  end

  // gating by mode and template
  wire [`LSW_TMPL_W-1:0] tmplSel = (mode == lsw_pkg::LSW_ALT_ACTIVE) ? altTmpl : actTmpl;
  wire [`LSW_TMPL_W-1:0] gate    = isRun ? tmplSel : {`LSW_TMPL_W{1'b0}};
  wire [NUM_DIV-1:0]     divEn;

  generate
    for (g = 0; g < NUM_DIV; g++) begin : gEn
      assign divEn[g] = divCfg[g][`LSW_DV_EN];
    end
  endgenerate

  // usb: routed 48 MHz level, or a pulse on each edge of a 24 MHz source;
  // at this sample rate the doubled form is a pulse train, not a square wave
  wire usbDirect = oscLvl[2];
  wire usbDouble = pick8(oscEdge, (usbSel == 2'h1) ? 3'h0 : (usbSel == 2'h2) ? 3'h2 : 3'h1);
  wire usbNext   = (usbSel == 2'h0) ? usbDirect : usbDouble;
  wire sysSrc    = pick8({1'b0, oscLvl[6:0]}, divCfg[0][`LSW_DV_SRC_HI:`LSW_DV_SRC_LO]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysClk       <= 1'b0;
      busClk       <= 1'b0;
      cpuClk       <= 1'b0;
      digClk       <= '0;
      anaClk       <= '0;
      usbClk       <= 1'b0;
      powerMode    <= 2'h0;
      subsysEnable <= '0;
    end else begin
      sysClk       <= sysSrc && isRun;
      busClk       <= divOut[0] && divEn[0] && isRun;
      cpuClk       <= divOut[0] && divEn[0] && gate[`LSW_TB_CPU];
      digClk       <= divOut[NUM_DIG:1] & divEn[NUM_DIG:1]
                      & gate[`LSW_TB_DIG +: NUM_DIG];
      anaClk       <= anaSkewed & divEn[NUM_DIV-1:ANA_BASE]
                      & gate[`LSW_TB_ANA +: NUM_ANA];
      usbClk       <= usbNext && gate[`LSW_TB_USB];
      powerMode    <= mode;
      subsysEnable <= gate;
    end
  end

  // register read, answered in the cycle after the strobe only
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (divHit) begin
      rdMux = divCfg[divIdx];
    end else begin
      unique case (addr)
        `LSW_OFF_MODE:     rdMux = {30'h0, mode};
        `LSW_OFF_ACT_TMPL: rdMux = {18'h0, actTmpl};
        `LSW_OFF_ALT_TMPL: rdMux = {18'h0, altTmpl};
        `LSW_OFF_SLOW_CFG: rdMux = slowCfg;
        `LSW_OFF_FAST_CFG: rdMux = fastCfg;
        `LSW_OFF_USB_CFG:  rdMux = {30'h0, usbSel};
        `LSW_OFF_COUNT:    rdMux = {11'h0, fastCnt, 3'h0, slowCnt};
        default:           rdMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h0000_0000;
    end else begin
      rdData <= rdStb ? rdMux : 32'h0000_0000;
    end
  end

endmodule : lsw_clock_ctrl

// file: lsw_defines.svh
`ifndef LSW_DEFINES_SVH
`define LSW_DEFINES_SVH

// register byte offsets
`define LSW_OFF_MODE        8'h00
`define LSW_OFF_ACT_TMPL    8'h04
`define LSW_OFF_ALT_TMPL    8'h08
`define LSW_OFF_SLOW_CFG    8'h0C
`define LSW_OFF_FAST_CFG    8'h10
`define LSW_OFF_USB_CFG     8'h14
`define LSW_OFF_COUNT       8'h18
`define LSW_OFF_DIV_BASE    8'h40

// template bit positions
`define LSW_TB_CPU          0
`define LSW_TB_DIG          1
`define LSW_TB_ANA          9
`define LSW_TB_USB          13
`define LSW_TMPL_W          14

// wake counter configuration fields
`define LSW_SC_WAKE         0
`define LSW_SC_IRQ          1
`define LSW_SC_RESET        2
`define LSW_SC_IVL_LO       4
`define LSW_SC_IVL_HI       7
`define LSW_FC_WAKE         0
`define LSW_FC_IRQ          1
`define LSW_FC_TC_LO        8
`define LSW_FC_TC_HI        12

// divider configuration fields
`define LSW_DV_DIV_HI       15
`define LSW_DV_SRC_LO       16
`define LSW_DV_SRC_HI       18
`define LSW_DV_SKEW_LO      20
`define LSW_DV_SKEW_HI      23
`define LSW_DV_EN           24

// reset values and minimum divide
`define LSW_RST_TMPL        14'h3F_FF
`define LSW_RST_SLOW_CFG    32'h0000_00A0
`define LSW_RST_FAST_CFG    32'h0000_1F00
`define LSW_RST_BUS_DIV     32'h0100_0002
`define LSW_RST_DIV         32'h0000_0002
`define LSW_DIV_MIN         16'h0002

// counts
`define LSW_WATCH_PER_SEC   15'h7F_FF
`define LSW_LP_DIV3_LAST    2'h2

`endif

// file: lsw_pkg.sv
package lsw_pkg;

  typedef enum logic [1:0] {
    LSW_ACTIVE,
    LSW_ALT_ACTIVE,
    LSW_SLEEP,
    LSW_HIBERNATE
  } lsw_mode_e;

  // clock source slots of every divider multiplexer; divider 0 ties slot 7 low
  typedef enum logic [2:0] {
    LSW_SRC_MAIN_INTERNAL_OSC,
    LSW_SRC_FAST_CRYSTAL_OSC,
    LSW_SRC_ROUTED,
    LSW_SRC_PLL,
    LSW_SRC_DOUBLER,
    LSW_SRC_FAST_LOWPOWER,
    LSW_SRC_WATCH_CRYSTAL_OSC,
    LSW_SRC_CHAIN
  } lsw_src_e;

endpackage : lsw_pkg

// file: lsw_osc_model.sv
`timescale 1ns/1ps
module lsw_osc_model (
  input  wire logic       clk,
  output logic      [7:0] oscIn
);
  initial oscIn = 8'h00;

  // pins rest low between ticks; each high lasts 8 cycles and each low at least 8, so the 3-flop sync sees it
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      oscIn[idx] <= 1'b1;
      repeat (8) @(posedge clk);
      oscIn[idx] <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulse
endmodule : lsw_osc_model

// file: lsw_ctrl_monitor.sv
`timescale 1ns/1ps
module lsw_ctrl_monitor #(
  parameter int NUM_DIG = 8,
  parameter int NUM_ANA = 4
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               pinWake,
  input wire logic               wrStb,
  input wire logic               rdStb,
  input wire logic [31:0]        rdData,
  input wire logic               heartbeatClock,
  input wire logic               fastLowpowerClock,
  input wire logic               slowWakeIrq,
  input wire logic               fastWakeIrq,
  input wire logic               rtcIrq,
  input wire logic               sysClk,
  input wire logic               busClk,
  input wire logic               cpuClk,
  input wire logic [NUM_DIG-1:0] digClk,
  input wire logic [NUM_ANA-1:0] anaClk,
  input wire logic               usbClk,
  input wire logic [1:0]         powerMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rd_idle_a: assert property (!$past(rdStb) |-> rdData == 32'h0000_0000)
    else $error("read data not idle");
  slow_pulse_a: assert property (slowWakeIrq |=> !slowWakeIrq)
    else $error("slow wake irq longer than one cycle");
  fast_pulse_a: assert property (fastWakeIrq |=> !fastWakeIrq)
    else $error("fast wake irq longer than one cycle");
  rtc_pulse_a: assert property (rtcIrq |=> !rtcIrq)
    else $error("rtc irq longer than one cycle");
  sleep_gate_a: assert property (powerMode == 2'h2 && $past(powerMode) == 2'h2 |->
    !sysClk && !busClk && !cpuClk && digClk == '0 && anaClk == '0 && !usbClk)
    else $error("clock running in sleep");
  hib_gate_a: assert property (powerMode == 2'h3 && $past(powerMode) == 2'h3 |->
    !sysClk && !busClk && !cpuClk && digClk == '0 && !usbClk && !heartbeatClock && !fastLowpowerClock)
    else $error("clock running in hibernate");
  hib_quiet_a: assert property (powerMode == 2'h3 && $past(powerMode) == 2'h3 |->
    !slowWakeIrq && !fastWakeIrq && !rtcIrq)
    else $error("timer event in hibernate");
  hib_hold_a: assert property (powerMode == 2'h3 && !$past(pinWake) && !$past(wrStb)
    |=> powerMode == 2'h3)
    else $error("hibernate left without pin wake");
  hib_wake_a: assert property (powerMode == 2'h3 && pinWake |-> ##2 powerMode == 2'h0)
    else $error("pin wake did not reach active");
endmodule : lsw_ctrl_monitor

bind lsw_clock_ctrl lsw_ctrl_monitor #(.NUM_DIG(NUM_DIG), .NUM_ANA(NUM_ANA)) lsw_ctrl_monitor_i (
  .clk(clk), .rst_n(rst_n), .pinWake(pinWake), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .heartbeatClock(heartbeatClock), .fastLowpowerClock(fastLowpowerClock), .slowWakeIrq(slowWakeIrq),
  .fastWakeIrq(fastWakeIrq), .rtcIrq(rtcIrq), .sysClk(sysClk), .busClk(busClk), .cpuClk(cpuClk),
  .digClk(digClk), .anaClk(anaClk), .usbClk(usbClk), .powerMode(powerMode));

// file: test_low_speed_clock_and_wake_timing.sv
`timescale 1ns/1ps
module test_low_speed_clock_and_wake_timing;
  logic clk, rst_n, cpuHalted, intWake, pinWake, wrStb, rdStb;
  logic [7:0] addr, oscIn;
  logic [31:0] wrData, rdData;
  logic heartbeatClock, fastLowpowerClock, dividedLowpowerClock, slowWakeIrq, fastWakeIrq, rtcIrq;
  logic sysClk, busClk, cpuClk, usbClk;
  logic [7:0] digClk;
  logic [3:0] anaClk;
  logic [1:0] powerMode;
  logic [13:0] subsysEnable;
  logic [11:0] sv, pv;
  logic [31:0] cnt [12];
  int errCount, checks, cyc;

  lsw_osc_model lsw_osc_model_i (.clk(clk), .oscIn(oscIn));
  lsw_clock_ctrl lsw_clock_ctrl_i (.clk(clk), .rst_n(rst_n), .oscIn(oscIn), .cpuHalted(cpuHalted),
    .intWake(intWake), .pinWake(pinWake), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .heartbeatClock(heartbeatClock), .fastLowpowerClock(fastLowpowerClock),
    .dividedLowpowerClock(dividedLowpowerClock), .slowWakeIrq(slowWakeIrq), .fastWakeIrq(fastWakeIrq),
    .rtcIrq(rtcIrq), .sysClk(sysClk), .busClk(busClk), .cpuClk(cpuClk), .digClk(digClk),
    .anaClk(anaClk), .usbClk(usbClk), .powerMode(powerMode), .subsysEnable(subsysEnable));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // rising edges: 0 slow irq, 1 fast irq, 2 divided clk, 3 digital 0, 4 digital 1, 5 usb,
  // 6 bus, 7 cpu, 8 heartbeat, 9 fast low-power, 10 analog 0, 11 system
  assign sv = {sysClk, anaClk[0], fastLowpowerClock, heartbeatClock, cpuClk, busClk,
               usbClk, digClk[1], digClk[0], dividedLowpowerClock, fastWakeIrq, slowWakeIrq};
  always @(posedge clk) begin
    for (int i = 0; i < 12; i++) if (sv[i] === 1'b1 && pv[i] !== 1'b1) cnt[i] = cnt[i] + 1;
    pv <= sv;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errCount = errCount + 1;
      complete_run();
    end
  end

  task automatic complete_run;
    if (errCount == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    checks = checks + 1;
    if (got !== e) begin
      errCount = errCount + 1;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk(nm, e, rdData);
  endtask : rd

  task automatic clr;
    #1 for (int i = 0; i < 12; i++) cnt[i] = 32'h0000_0000;
  endtask : clr

  // one-cycle pulse on a wake input, then time for mode and powerMode to follow
  task automatic wake(input bit pin);
    @(posedge clk);
    if (pin) pinWake <= 1'b1;
    else intWake <= 1'b1;
    @(posedge clk);
    pinWake <= 1'b0;
    intWake <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : wake

  initial begin
    {rst_n, cpuHalted, intWake, pinWake, wrStb, rdStb, addr, wrData} = '0;
    {errCount, checks, cyc, pv} = '0;
    clr();
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, 32'h0000_3FFF, "active template");
    rd(8'h08, 32'h0000_3FFF, "alt template");
    rd(8'h0C, 32'h0000_00A0, "slow cfg");
    rd(8'h10, 32'h0000_1F00, "fast cfg");
    rd(8'h40, 32'h0100_0002, "bus divider");
    rd(8'h44, 32'h0000_0002, "digital divider");
    rd(8'h30, 32'h0000_0000, "unmapped");
    wr(8'h10, 32'h0000_0202);
    clr();
    lsw_osc_model_i.pulse(5, 6);
    chk("fast irqs", 32'h0000_0002, cnt[1]);
    chk("divided rises", 32'h0000_0002, cnt[2]);
    chk("fast lp rises", 32'h0000_0006, cnt[9]);
    rd(8'h18, 32'h0000_0000, "fast wrap count");
    lsw_osc_model_i.pulse(7, 3);
    rd(8'h18, 32'h0000_0003, "slow count");
    wr(8'h0C, 32'h0000_0016);
    rd(8'h18, 32'h0000_0000, "slow count reset");
    @(posedge clk);
    cpuHalted <= 1'b1;
    lsw_osc_model_i.pulse(7, 2);
    rd(8'h18, 32'h0000_0000, "halted count");
    @(posedge clk);
    cpuHalted <= 1'b0;
    clr();
    lsw_osc_model_i.pulse(7, 4);
    rd(8'h18, 32'h0000_0004, "slow count run");
    chk("slow irqs", 32'h0000_0002, cnt[0]);
    chk("heartbeat rises", 32'h0000_0004, cnt[8]);
    rd(8'h0C, 32'h0000_0012, "slow cfg");
    wr(8'h00, 32'h0000_0001);
    rd(8'h00, 32'h0000_0001, "alt mode");
    wake(1'b0);
    chk("int wake mode", 32'h0000_0000, {30'h0000_0000, powerMode});
    wr(8'h04, 32'h0000_3FFE);
    wr(8'h10, 32'h0000_0201);
    chk("active gate", 32'h0000_3FFE, {18'h0, subsysEnable});
    wr(8'h00, 32'h0000_0002);
    rd(8'h00, 32'h0000_0002, "sleep mode");
    chk("sleep gate", 32'h0000_0000, {18'h0, subsysEnable});
    lsw_osc_model_i.pulse(5, 3);
    chk("sleep wake mode", 32'h0000_0000, {30'h0000_0000, powerMode});
    rd(8'h04, 32'h0000_3FFF, "cpu template set");
    rd(8'h10, 32'h0000_0201, "fast cfg kept");
    wr(8'h00, 32'h0000_0003);
    wake(1'b0);
    lsw_osc_model_i.pulse(5, 2);
    rd(8'h00, 32'h0000_0003, "hibernate mode");
    rd(8'h18, 32'h0000_0004, "hibernate count");
    wake(1'b1);
    chk("pin wake mode", 32'h0000_0000, {30'h0000_0000, powerMode});
    wr(8'h0C, 32'h0000_0011);
    wr(8'h00, 32'h0000_0002);
    lsw_osc_model_i.pulse(7, 1);
    chk("slow wake early", 32'h0000_0002, {30'h0000_0000, powerMode});
    lsw_osc_model_i.pulse(7, 1);
    chk("slow wake mode", 32'h0000_0000, {30'h0000_0000, powerMode});
    wr(8'h44, 32'h0100_0000);
    wr(8'h48, 32'h0107_0002);
    wr(8'h64, 32'h0130_0000);
    wr(8'h14, 32'h0000_0001);
    lsw_osc_model_i.pulse(0, 1);
    clr();
    lsw_osc_model_i.pulse(0, 8);
    chk("divide by two", 32'h0000_0004, cnt[3]);
    chk("chained divider", 32'h0000_0002, cnt[4]);
    chk("usb pulses", 32'h0000_0010, cnt[5]);
    chk("bus clock", 32'h0000_0004, cnt[6]);
    chk("cpu clock", 32'h0000_0004, cnt[7]);
    chk("analog clock", 32'h0000_0004, cnt[10]);
    chk("system clock", 32'h0000_0008, cnt[11]);
    wr(8'h04, 32'h0000_3FFE);
    clr();
    lsw_osc_model_i.pulse(0, 4);
    chk("bus running", 32'h0000_0002, cnt[6]);
    chk("cpu gated", 32'h0000_0000, cnt[7]);
    complete_run();
  end
endmodule : test_low_speed_clock_and_wake_timing
